// ### pse_pkg.sv
// constants and types of the transmit data encoder stage
package pse_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [5:0] ADDR_TX_CONFIG_ONE  = 6'h05;
    localparam logic [5:0] ADDR_SCRAMBLER_SEED = 6'h08;
    localparam logic [5:0] ADDR_PLAIN_LEAD_CNT = 6'h27;

    localparam logic [7:0] RST_TX_CONFIG_ONE   = 8'h25;
    localparam logic [7:0] RST_SCRAMBLER_SEED  = 8'hab;
    localparam logic [7:0] RST_PLAIN_LEAD_CNT  = 8'h00;

    // ********************************
    // field layout of tx_config_one
    // ********************************
    localparam int INVERT_BIT    = 3;
    localparam int LINE_CODE_LSB = 0;
    localparam int LINE_CODE_W   = 3;

    // ********************************
    // pseudo-random generator and data synchroniser reset
    // ********************************
    localparam int         SCRAMBLER_SEED_W       = 9;
    localparam int         SCRAMBLER_SEED_TAP_HI  = 8;
    localparam int         SCRAMBLER_SEED_TAP_LO  = 4;
    localparam logic [2:0] SYNC_RST     = 3'h0;
    localparam logic [8:0] SCRAMBLER_SEED_RST     = 9'h000;

    typedef enum logic [2:0] {
        LC_MANCHESTER  = 3'b000,
        LC_DIFF_MANCH  = 3'b001,
        LC_BIPH_SPACE  = 3'b010,
        LC_BIPH_MARK   = 3'b011,
        LC_MILLER      = 3'b100,
        LC_NRZ         = 3'b101,
        LC_SCRAMBLE    = 3'b110,
        LC_ZERO        = 3'b111
    } pse_line_code_t;

    // register write request from the serial command port
    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } pse_reg_req_t;

    // all state of the encoder apart from the reset release pipe
    typedef struct packed {
        logic [7:0]           tx_config_one;
        logic [7:0]           scrambler_seed;
        logic [7:0]           plain_lead_bit_count;
        logic [2:0]           sync;
        logic                 data_q;
        logic [SCRAMBLER_SEED_W-1:0]    lfsr;
        logic [7:0]           lead_cnt;
        logic                 running;
        logic                 second_half;
        logic                 held_half;
        logic                 level;
        logic                 prev_bit;
        logic                 chip;
        logic                 encoding;
        logic [7:0]           rdata;
    } pse_state_t;

endpackage : pse_pkg

// ### pse_encoder.sv
// transmit data encoder: pseudo-random scrambler, line coder, plain lead bits
// ********************************
// Notes on behaviour
// [RL1] A nine-stage pseudo-random generator with fixed taps can produce a test pattern.
// [RL2] While scrambling, each host bit is XORed with the generator output bit.
// [RL3] The seed sits in a writable 8-bit register at 0x08 that resets to 0xab.
// [RL4] The host never programs an all-zero seed, which would lock the generator at zero.
// [RL5] The seed is reloaded into the generator at the start of every transmission.
// [RL6] The count at 0x27 sets how many leading bits go plain; zero scrambles from bit one.
// [RL7] With a count of N the first N bits pass unscrambled.
// [RL8] The same count holds off the line coder, so leading bits go out as plain NRZ.
// [RL9] Bit 3 of 0x05 inverts every encoded chip when set.
// [RL10] Bits 2:0 of 0x05 select the line code, and code 111 sends constant zero.
// [RL11] The host enables encoding and data sync together, so the coder runs synchronously.
// [RL12] NRZ and scrambling send one chip per bit, all other codes two chips per bit.
// [RL13] The generator steps once per scrambled bit with polynomial x^9 + x^5 + 1.
// [RL14] A lead counter reloads at start, counts down per bit, and coding starts at zero.
// ********************************
`timescale 1ns/1ps

module pse_encoder (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // register writes and readback
    input  wire pse_pkg::pse_reg_req_t reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    // transmission control, same clock
    input  wire logic                  tx_start_i,
    input  wire logic                  tx_active_i,
    input  wire logic                  chip_tick_i,
    // serial data pin from the host
    input  wire logic                  tx_data_i,
    // encoded chip stream and status
    output logic                       chip_o,
    output logic                       encoding_o
);

    // ********************************
    // reset release
    // ********************************
    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    // ********************************
    // next state
    // ********************************
    pse_pkg::pse_state_t st;
    pse_pkg::pse_state_t next_st;

    always_comb begin
        logic                    d;
        logic                    h0;
        logic                    h1;
        logic                    two_chips;
        logic                    coded;
        logic                    inv;
        pse_pkg::pse_line_code_t code;
        d         = 1'b0;
        h0        = 1'b0;
        h1        = 1'b0;
        next_st   = st;
        code      = pse_pkg::pse_line_code_t'(
                        st.tx_config_one[pse_pkg::LINE_CODE_LSB +: pse_pkg::LINE_CODE_W]);
        inv       = st.tx_config_one[pse_pkg::INVERT_BIT];
        two_chips = (code != pse_pkg::LC_NRZ) && (code != pse_pkg::LC_SCRAMBLE); // RL12
        coded     = (st.lead_cnt == 8'h00);                                       // RL14

        // a level counts once the second and third stages agree
        next_st.sync = {st.sync[1:0], tx_data_i};
        if (st.sync[1] == st.sync[2]) begin
            next_st.data_q = st.sync[2];
        end

        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                pse_pkg::ADDR_TX_CONFIG_ONE:  next_st.tx_config_one        = reg_req_i.wdata;
                pse_pkg::ADDR_SCRAMBLER_SEED: next_st.scrambler_seed       = reg_req_i.wdata; // RL3
                pse_pkg::ADDR_PLAIN_LEAD_CNT: next_st.plain_lead_bit_count = reg_req_i.wdata; // RL6
                default: ;
            endcase
        end
        next_st.rdata = st.tx_config_one;

        if (tx_start_i) begin
            // restart from the same sequence every telegram
            next_st.lfsr        = {1'b0, st.scrambler_seed};  // RL5
            next_st.lead_cnt    = st.plain_lead_bit_count;    // RL14
            next_st.running     = 1'b1;
            next_st.second_half = 1'b0;
            next_st.level       = 1'b0;
            next_st.prev_bit    = 1'b1;
            next_st.chip        = 1'b0;
        end else if (!tx_active_i) begin
            next_st.running = 1'b0;
            next_st.chip    = 1'b0;
        end else if (st.running && chip_tick_i) begin
            if (st.second_half) begin
                next_st.second_half = 1'b0;
                next_st.chip        = st.held_half;
                if (!coded) begin
                    // a lead bit ends on its last chip, so coding never starts mid-bit
                    next_st.lead_cnt = st.lead_cnt - 8'h01;    // RL14
                end
            end else begin
                d = st.data_q;
                if (!coded) begin
                    // plain NRZ lead bit, same length as a coded bit
                    h0 = d;                                    // RL7
                    h1 = d;                                    // RL8
                    if (!two_chips) begin
                        next_st.lead_cnt = st.lead_cnt - 8'h01; // RL14
                    end
                end else begin
                    case (code)                                // RL10
                        pse_pkg::LC_MANCHESTER: begin
                            h0 = d;
                            h1 = ~d;
                        end
                        pse_pkg::LC_DIFF_MANCH: begin
                            h0 = d ? st.level : ~st.level;
                            h1 = ~h0;
                        end
                        pse_pkg::LC_BIPH_SPACE: begin
                            h0 = ~st.level;
                            h1 = d ? h0 : ~h0;
                        end
                        pse_pkg::LC_BIPH_MARK: begin
                            h0 = ~st.level;
                            h1 = d ? ~h0 : h0;
                        end
                        pse_pkg::LC_MILLER: begin
                            h0 = (!d && !st.prev_bit) ? ~st.level : st.level;
                            h1 = d ? ~h0 : h0;
                        end
                        pse_pkg::LC_NRZ: begin
                            h0 = d;
                            h1 = d;
                        end
                        pse_pkg::LC_SCRAMBLE: begin
                            h0 = d ^ st.lfsr[pse_pkg::SCRAMBLER_SEED_TAP_HI];                  // RL2
                            h1 = h0;
                            next_st.lfsr = {st.lfsr[pse_pkg::SCRAMBLER_SEED_W-2:0],
                                            st.lfsr[pse_pkg::SCRAMBLER_SEED_TAP_HI]
                                            ^ st.lfsr[pse_pkg::SCRAMBLER_SEED_TAP_LO]};         // RL1 RL13
                        end
                        default: begin
                            h0 = 1'b0;
                            h1 = 1'b0;
                        end
                    endcase
                end
                // level tracks the uninverted stream, so differential codes
                // keep their transition sense when the output is inverted
                next_st.prev_bit    = d;
                next_st.level       = h1;
                // inversion only touches coded chips; lead bits stay plain
                next_st.chip        = h0 ^ (inv & coded);      // RL9
                next_st.held_half   = h1 ^ (inv & coded);      // RL9
                next_st.second_half = two_chips;               // RL12
            end
        end
        next_st.encoding = st.running && (st.lead_cnt == 8'h00);
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st                      <= '0;
            st.tx_config_one        <= pse_pkg::RST_TX_CONFIG_ONE;
            st.scrambler_seed       <= pse_pkg::RST_SCRAMBLER_SEED; // RL3
            st.plain_lead_bit_count <= pse_pkg::RST_PLAIN_LEAD_CNT;
            st.sync                 <= pse_pkg::SYNC_RST;
            st.lfsr                 <= pse_pkg::SCRAMBLER_SEED_RST;
        end else begin
            st <= next_st;
        end
    end

    // level inversion is applied before the output flop, so chip_o is a flop
    assign chip_o      = st.chip;
    assign encoding_o  = st.encoding;
    assign reg_rdata_o = st.rdata;

endmodule : pse_encoder

// ### pse_encoder_monitor.sv
// port checker of the transmit data encoder
`timescale 1ns/1ps
module pse_encoder_monitor (
    // watched ports
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire pse_pkg::pse_reg_req_t reg_req_i,
    input wire logic [7:0]            reg_rdata_o,
    input wire logic                  tx_start_i,
    input wire logic                  tx_active_i,
    input wire logic                  chip_tick_i,
    input wire logic                  tx_data_i,
    input wire logic                  chip_o,
    input wire logic                  encoding_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic tk = chip_tick_i && tx_active_i && !tx_start_i;
    a_idle_chip_low: assert property (!tx_active_i |=> !chip_o)
        else $error("chip high while idle");
    a_start_clears: assert property (tx_start_i |=> !chip_o)
        else $error("chip not cleared at start");
    a_chip_holds: assert property ((tx_active_i && !chip_tick_i && !tx_start_i) |=> $stable(chip_o))
        else $error("chip moved without tick");
    a_zero_code: assert property ((tk && encoding_o && reg_rdata_o[3:0] == 4'h7) |=> !chip_o)
        else $error("unused code not zero");
    a_zero_invert: assert property ((tk && encoding_o && reg_rdata_o[3:0] == 4'hf) |=> chip_o)
        else $error("inverted unused code not one");
    a_nrz_follows: assert property ((tk && reg_rdata_o[3:0] == 4'h5) |=> chip_o == $past(tx_data_i, 2))
        else $error("nrz chip differs from data");
    a_cfg_readback: assert property ((reg_req_i.wr && reg_req_i.addr == pse_pkg::ADDR_TX_CONFIG_ONE)
        |-> ##2 reg_rdata_o == $past(reg_req_i.wdata, 2)) else $error("config write lost");
    a_other_kept: assert property ((reg_req_i.wr && reg_req_i.addr != pse_pkg::ADDR_TX_CONFIG_ONE)
        |-> ##2 $stable(reg_rdata_o)) else $error("config changed by other write");
    c_scramble: cover property (tk && reg_rdata_o[2:0] == 3'h6);
    c_invert: cover property (tk && reg_rdata_o[3:0] == 4'h8);
    c_coding_on: cover property ($rose(encoding_o));
endmodule : pse_encoder_monitor

// ### pse_host_model.sv
// host model: shifts a bit pattern onto the serial data pin
`timescale 1ns/1ps
module pse_host_model (
    // pacing
    input  wire logic        clk_i,
    input  wire logic        tick_i,
    input  wire logic        active_i,
    input  wire logic        two_i,
    // pattern
    input  wire logic        load_i,
    input  wire logic [31:0] pat_i,
    // serial pin
    output logic             data_o
);
    logic [31:0] sh;
    logic        ph;
    // next bit after the last chip only, so the pin is steady at every first chip
    always_ff @(posedge clk_i) begin
        if (load_i) begin
            sh <= pat_i;
            ph <= 1'b0;
        end else if (tick_i && active_i) begin
            if (!two_i || ph) sh <= {sh[30:0], ~sh[0]};
            ph <= two_i & ~ph;
        end
    end
    assign data_o = load_i ? pat_i[31] : sh[31];
endmodule : pse_host_model

// ### pse_encoder_test.sv
// self-checking bench of the transmit data encoder
`timescale 1ns/1ps
module pse_encoder_test;
    logic clk_i, rst_n_i, tx_start_i, tx_active_i, chip_tick_i, tx_data_i, chip_o, encoding_o;
    logic ld, two;
    logic [7:0] reg_rdata_o, seed_m;
    logic [31:0] rnd;
    pse_pkg::pse_reg_req_t reg_req_i;
    int error_cnt, n_compared;
    logic exp_q[$];
    // config, seed (0 keeps it), lead count
    localparam logic [23:0] TBL [14] = '{24'h050000, 24'h060000, 24'h065a04, 24'h060004,
        24'h060010, 24'h0e0000, 24'h000003, 24'h080002, 24'h010000, 24'h020000,
        24'h030000, 24'h040000, 24'h070000, 24'h0f0000};
    pse_encoder u_pse_encoder (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
        .reg_rdata_o(reg_rdata_o), .tx_start_i(tx_start_i), .tx_active_i(tx_active_i),
        .chip_tick_i(chip_tick_i), .tx_data_i(tx_data_i), .chip_o(chip_o), .encoding_o(encoding_o));
    pse_host_model u_pse_host_model (.clk_i(clk_i), .tick_i(chip_tick_i), .active_i(tx_active_i),
        .two_i(two), .load_i(ld), .pat_i(rnd), .data_o(tx_data_i));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i); #1 reg_req_i = '{1'b1, a, d};
        @(posedge clk_i); #1 reg_req_i.wr = 1'b0;
    endtask : wr
    task automatic tick;
        @(posedge clk_i); #1 chip_tick_i = 1'b1;
        @(posedge clk_i); #1 chip_tick_i = 1'b0;
        repeat (14) @(posedge clk_i);
    endtask : tick
    task automatic telegram(input logic [23:0] t);
        logic [8:0] lfsr;
        logic [7:0] lead;
        logic [2:0] code;
        logic lvl, pb, b, c0, c1, n2;
        code = t[18:16];
        lead = t[7:0];
        n2 = code < 3'h5 || code == 3'h7;
        wr(pse_pkg::ADDR_TX_CONFIG_ONE, t[23:16]);
        if (t[15:8] != 8'h00) begin
            wr(pse_pkg::ADDR_SCRAMBLER_SEED, t[15:8]);
            seed_m = t[15:8];
        end
        wr(pse_pkg::ADDR_PLAIN_LEAD_CNT, lead);
        wr(6'h3f, 8'hff);
        check("reg_rdata_o", t[23:16], reg_rdata_o);
        lfsr = {1'b0, seed_m};
        @(posedge clk_i); #1 rnd = xs(rnd);
        ld = 1'b1;
        two = n2;
        @(posedge clk_i); #1 ld = 1'b0;
        // first bit must clear the pin synchroniser before the first tick
        repeat (4) @(posedge clk_i);
        #1 tx_start_i = 1'b1;
        @(posedge clk_i); #1 tx_start_i = 1'b0;
        tx_active_i = 1'b1;
        lvl = 1'b0;
        pb = 1'b1;
        for (int i = 0; i < 20; i++) begin
            if (i > 0) begin
                #1 check("encoding_o", {7'h0, lead == 8'h00}, {7'h0, encoding_o});
            end
            b = rnd[31 - i];
            c1 = b;
            if (lead != 8'h00) begin
                c0 = b;
                lvl = b;
                pb = b;
                lead--;
            end else begin
                case (code)
                    3'h0: begin c0 = b; c1 = !b; end
                    3'h1: begin c0 = b ? lvl : !lvl; c1 = !c0; end
                    3'h2: begin c0 = !lvl; c1 = b ? c0 : !c0; end
                    3'h3: begin c0 = !lvl; c1 = b ? !c0 : c0; end
                    3'h4: begin c0 = (b || pb) ? lvl : !lvl; c1 = b ? !c0 : c0; end
                    3'h6: begin c0 = b ^ lfsr[8]; lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]}; end
                    3'h7: begin c0 = 1'b0; c1 = 1'b0; end
                    default: c0 = b;
                endcase
                lvl = n2 ? c1 : c0;
                pb = b;
                c0 ^= t[19];
                c1 ^= t[19];
            end
            exp_q.push_back(c0);
            tick();
            if (n2) begin
                exp_q.push_back(c1);
                tick();
            end
        end
        #1 tx_active_i = 1'b0;
        check("encoding_o", 8'h01, {7'h0, encoding_o});
        repeat (2) @(posedge clk_i);
        #1 check("chip_o idle", 8'h00, {7'h0, chip_o});
        check("encoding_o idle", 8'h00, {7'h0, encoding_o});
    endtask : telegram
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // chip lands one edge after the tick that launched it
    initial forever begin
        @(posedge clk_i);
        if (chip_tick_i === 1'b1 && tx_active_i === 1'b1) begin
            @(posedge clk_i); #2 check("chip_o", {7'h0, exp_q.pop_front()}, {7'h0, chip_o});
        end
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end
    initial begin
        {rst_n_i, tx_start_i, tx_active_i, chip_tick_i, two, error_cnt, n_compared} = '0;
        reg_req_i = '0;
        ld = 1'b1;
        rnd = 32'hd1b9;
        seed_m = pse_pkg::RST_SCRAMBLER_SEED;
        repeat (12) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1 check("reg_rdata_o", pse_pkg::RST_TX_CONFIG_ONE, reg_rdata_o);
        foreach (TBL[k]) telegram(TBL[k]);
        end_of_test();
    end
endmodule : pse_encoder_test
bind pse_encoder pse_encoder_monitor u_pse_encoder_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .tx_start_i(tx_start_i),
    .tx_active_i(tx_active_i), .chip_tick_i(chip_tick_i), .tx_data_i(tx_data_i),
    .chip_o(chip_o), .encoding_o(encoding_o));
